// ---- verilog/crc_scan_regs.svh ----
`ifndef CRC_SCAN_REGS_SVH
`define CRC_SCAN_REGS_SVH

// ============================================================
// Register indices; the byte address is four times the index.
`define IDX_SCAN_LOW      12'hf49
`define IDX_SCAN_HIGH     12'hf4c
`define IDX_SCAN_CTRL     12'hf4f
`define IDX_SCAN_TRIG     12'hf50
`define IDX_CRC_DATA      12'hf74
`define IDX_CRC_ACC       12'hf76
`define IDX_CRC_SHIFT     12'hf78
`define IDX_CRC_TAPS      12'hf7a
`define IDX_CRC_CTRL      12'hf7c
`define IDX_CRC_LEN       12'hf7d
`define IDX_PERIPH_DIS    12'hf80

// ============================================================
// Scan control field positions.
`define SCTL_ON           7
`define SCTL_GO           6
`define SCTL_BUSY         5
`define SCTL_INVALID      4
`define SCTL_INTERRUPT_PRIORITY_SELECT         3

// ============================================================
// CRC control field positions.
`define CCTL_EN           7
`define CCTL_GO           6
`define CCTL_BUSY         5
`define CCTL_ZERO_AUGMENT         4
`define CCTL_SHIFT_DIRECTION       1
`define CCTL_FULL         0

// ============================================================
// Peripheral disable field positions.
`define PDIS_CRC          0
`define PDIS_SCAN         1
`define PDIS_FUSE         2

// ============================================================
// Reset values.
`define RST_ADDR          24'h00_0000
`define RST_BYTE          8'h00
`define RST_HALF          16'h0000
`define RST_TAPS          16'h0001
`define RST_WORD          32'h0000_0000

`endif

// ---- verilog/crc_scan_pkg.sv ----
`default_nettype none

package crc_scan_pkg;

  // Debug interaction states, one-hot.
  typedef enum logic [2:0] {
    DBG_RUN    = 3'b001,
    DBG_HALT   = 3'b010,
    DBG_RESUME = 3'b100
  } dbg_state_e;

  // Scanner operating modes as encoded in the mode field.
  typedef enum logic [1:0] {
    MODE_CONC  = 2'b00,
    MODE_BURST = 2'b01,
    MODE_PEEK  = 2'b10,
    MODE_TRIG  = 2'b11
  } scan_mode_e;

endpackage

`default_nettype wire

// ---- verilog/scan_debug_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none

module scan_debug_ctrl (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic burstMode,
  input  wire logic scanPending,
  input  wire logic pcBreak,
  input  wire logic dataBreak,
  input  wire logic stepDone,
  input  wire logic swBreak,
  input  wire logic extHalt,
  input  wire logic onGoInstr,
  input  wire logic debugExit,
  output logic      allowScan,
  output logic      frozen,
  output logic      debugEnter_r,
  output logic      holderExec_r
);

  // ============================================================
  // State
  crc_scan_pkg::dbg_state_e state_r;
  crc_scan_pkg::dbg_state_e state_nxt;
  logic                     heldSw_r;
  logic                     anyHalt;

  assign anyHalt = pcBreak | dataBreak | stepDone | swBreak | extHalt;

  // A data breakpoint blocks the scan of its own cycle so that it is
  // deferred; every other halt lets a ready scan finish first.
  always_comb begin
    allowScan = 1'b0;
    state_nxt = state_r;
    unique case (state_r)
      crc_scan_pkg::DBG_RUN: begin
        allowScan = ~dataBreak;
        if (anyHalt) begin
          state_nxt = crc_scan_pkg::DBG_HALT;
        end
      end
      crc_scan_pkg::DBG_HALT: begin
        if (debugExit) begin
          state_nxt = crc_scan_pkg::DBG_RESUME;
        end
      end
      crc_scan_pkg::DBG_RESUME: begin
        allowScan = ~dataBreak;
        state_nxt = anyHalt ? crc_scan_pkg::DBG_HALT : crc_scan_pkg::DBG_RUN;
      end
    endcase
  end

  // The scanner stays frozen for the whole halt.
  assign frozen = (state_r == crc_scan_pkg::DBG_HALT);

  // State register.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= crc_scan_pkg::DBG_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Entry is reported one cycle after the halt request, after any scan
  // read granted in the request cycle; in burst mode no read is pending
  // on the go instruction because the go bit is not yet set.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      debugEnter_r <= 1'b0;
    end else begin
      debugEnter_r <= (state_r != crc_scan_pkg::DBG_HALT) & anyHalt;
    end
  end

  // A software breakpoint on the go instruction in burst mode is run
  // from the debug instruction holder once the halt ends.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      heldSw_r     <= 1'b0;
      holderExec_r <= 1'b0;
    end else begin
      holderExec_r <= 1'b0;
      if ((state_r != crc_scan_pkg::DBG_HALT) & swBreak) begin
        heldSw_r <= burstMode & onGoInstr;
      end
      if ((state_r == crc_scan_pkg::DBG_HALT) & debugExit) begin
        holderExec_r <= heldSw_r;
        heldSw_r     <= 1'b0;
      end
    end
  end

  // The pending flag is only mirrored here; the parent does the stall.
  logic unusedPend;
  assign unusedPend = scanPending;

endmodule

`default_nettype wire

// ---- verilog/crc_scan_ctrl.sv ----
// Operation
// - Two-bit mode field selects scanner behaviour.
// - Debug halt freezes scanner; registers stay readable.
// - PC breakpoint: pending scan completes before entry.
// - Data breakpoint: same-cycle scan deferred past exit.
// - Burst: break on go instruction delays burst.
// - Running burst yields to external debug halt.
// - Single step: ready scan reads before re-entry.
// - Software breakpoint: stalling scan runs, then entry.
// - Held go instruction runs from holder at exit.
// - Separate disable bits for CRC and scanner.
// - Scanner disable works only with fuse set.
// - Fuse cleared: scanner gone, disable bit ignored.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "crc_scan_regs.svh"

module crc_scan_ctrl (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scannerFuseEnable,
  input  wire logic        scanTrigger,
  input  wire logic        deadCycle,
  input  wire logic        pcBreak,
  input  wire logic        dataBreak,
  input  wire logic        stepDone,
  input  wire logic        swBreak,
  input  wire logic        extHalt,
  input  wire logic        onGoInstr,
  input  wire logic        debugExit,
  output logic             flashRead,
  output logic      [23:0] flashAddr,
  output logic             cpuStall,
  output logic             debugEnter,
  output logic             holderExec
);

  // ============================================================
  // Bus slave state
  logic        wrPend_r;
  logic [11:0] wrIdx_r;
  logic [31:0] rdNxt;
  logic [11:0] addrIdx;
  logic        addrTake;

  // ============================================================
  // Register state
  logic [23:0] scanLow_r;
  logic [23:0] scanHigh_r;
  logic        scanOn_r;
  logic        scan_run_bit_r;
  logic        scanInvalid_r;
  logic        scanIntm_r;
  logic [1:0]  scanMode_r;
  logic [3:0]  trigSel_r;
  logic [15:0] crcData_r;
  logic [15:0] crc_accumulator_r;
  logic [15:0] crc_shifter_r;
  logic [15:0] crcTaps_r;
  logic        crcEn_r;
  logic        crcGo_r;
  logic        crcAccm_r;
  logic        crcShiftm_r;
  logic        crcFull_r;
  logic [7:0]  crcLen_r;
  logic        crcDis_r;
  logic        scanDis_r;
  logic        trigPend_r;

  // ============================================================
  // Scanner control terms
  logic crcOff;
  logic scanOff;
  logic scanPending;
  logic scanDo;
  logic lastAddr;
  logic burstMode;
  logic allowScan;
  logic frozen;
  logic wrCtrl;

  // Requests are taken on the edge that sees a selected non-idle
  // transfer with hready high; only bit 1 of htrans matters.
  assign addrTake = hsel & htrans[1] & hready;
  assign addrIdx  = haddr[13:2];

  // Without the fuse the scanner is gone for good and its disable bit
  // is ignored; with the fuse the disable bit takes effect.
  assign scanOff = ~scannerFuseEnable | scanDis_r;
  assign crcOff  = crcDis_r;

  // Pending scan per mode: concurrent and burst always want the flash,
  // triggered waits for a trigger and peek waits for a dead cycle.
  assign burstMode = (scanMode_r == crc_scan_pkg::MODE_BURST);
  always_comb begin
    scanPending = 1'b0;
    if (scanOn_r & scan_run_bit_r & ~scanOff) begin
      unique case (crc_scan_pkg::scan_mode_e'(scanMode_r))
        crc_scan_pkg::MODE_CONC:  scanPending = 1'b1;
        crc_scan_pkg::MODE_BURST: scanPending = 1'b1;
        crc_scan_pkg::MODE_PEEK:  scanPending = deadCycle;
        crc_scan_pkg::MODE_TRIG:  scanPending = trigPend_r;
      endcase
    end
  end

  // A read happens only when debug allows it and the scanner is not
  // frozen; a disabled scanner never touches the flash.
  assign scanDo   = scanPending & allowScan & ~frozen;
  assign lastAddr = (scanLow_r >= scanHigh_r);
  assign wrCtrl   = wrPend_r & (wrIdx_r == `IDX_SCAN_CTRL) & ~scanOff;

  // ============================================================
  // Debug interaction
  scan_debug_ctrl scan_debug_ctrl_i (
    .mclk         (mclk),
    .rstn         (rstn),
    .burstMode    (burstMode),
    .scanPending  (scanPending),
    .pcBreak      (pcBreak),
    .dataBreak    (dataBreak),
    .stepDone     (stepDone),
    .swBreak      (swBreak),
    .extHalt      (extHalt),
    .onGoInstr    (onGoInstr),
    .debugExit    (debugExit),
    .allowScan    (allowScan),
    .frozen       (frozen),
    .debugEnter_r (debugEnter),
    .holderExec_r (holderExec)
  );

  // ============================================================
  // Bus slave
  // The write address is held over to the data phase, when hwdata
  // stands.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wrPend_r <= 1'b0;
      wrIdx_r  <= 12'h000;
    end else begin
      wrPend_r <= addrTake & hwrite;
      wrIdx_r  <= addrIdx;
    end
  end

  // Read data is looked up in the address phase so that it stands in
  // the data phase with no wait state; unmapped words read as zero.
  always_comb begin
    rdNxt = `RST_WORD;
    unique case (addrIdx)
      `IDX_SCAN_LOW:   rdNxt = {8'h00, scanLow_r};
      `IDX_SCAN_HIGH:  rdNxt = {8'h00, scanHigh_r};
      `IDX_SCAN_CTRL:  rdNxt = {24'h00_0000, scanOn_r, scan_run_bit_r,
                                scan_run_bit_r & scanOn_r, scanInvalid_r,
                                scanIntm_r, 1'b0, scanMode_r};
      `IDX_SCAN_TRIG:  rdNxt = {28'h000_0000, trigSel_r};
      `IDX_CRC_DATA:   rdNxt = {16'h0000, crcData_r};
      `IDX_CRC_ACC:    rdNxt = {16'h0000, crc_accumulator_r};
      `IDX_CRC_SHIFT:  rdNxt = {16'h0000, crc_shifter_r};
      `IDX_CRC_TAPS:   rdNxt = {16'h0000, crcTaps_r[15:1], 1'b1};
      `IDX_CRC_CTRL:   rdNxt = {24'h00_0000, crcEn_r, crcGo_r,
                                crcGo_r & crcFull_r, crcAccm_r,
                                2'b00, crcShiftm_r, crcFull_r};
      `IDX_CRC_LEN:    rdNxt = {24'h00_0000, crcLen_r};
      `IDX_PERIPH_DIS: rdNxt = {29'h0000_0000, scannerFuseEnable,
                                scanDis_r, crcDis_r};
      default:         rdNxt = `RST_WORD;
    endcase
  end

  // Answer: always ready, always OKAY; data registered.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hrdata    <= `RST_WORD;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addrTake & ~hwrite) begin
        hrdata <= rdNxt;
      end
    end
  end

  // ============================================================
  // Peripheral disable register
  // This register itself is never disabled, so software can always
  // bring the CRC back, and the scanner while the fuse is set.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      crcDis_r  <= 1'b0;
      scanDis_r <= 1'b0;
    end else if (wrPend_r & (wrIdx_r == `IDX_PERIPH_DIS)) begin
      crcDis_r  <= hwdata[`PDIS_CRC];
      scanDis_r <= hwdata[`PDIS_SCAN];
    end
  end

  // ============================================================
  // Scanner address registers
  // The low address walks up after each read but the last, so a debugger reading it
  // during a halt sees the next word to be scanned.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scanLow_r  <= `RST_ADDR;
      scanHigh_r <= `RST_ADDR;
    end else if (scanOff) begin
      scanLow_r  <= `RST_ADDR;
      scanHigh_r <= `RST_ADDR;
    end else begin
      if (scanDo & ~lastAddr) begin
        scanLow_r <= 24'(scanLow_r + 24'h00_0001);
      end
      if (wrPend_r & (wrIdx_r == `IDX_SCAN_LOW)) begin
        scanLow_r <= hwdata[23:0];
      end
      if (wrPend_r & (wrIdx_r == `IDX_SCAN_HIGH)) begin
        scanHigh_r <= hwdata[23:0];
      end
    end
  end

  // ============================================================
  // Scanner control register
  // Hardware clears go after the last word; a software write in the
  // same cycle is applied afterwards and so wins.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scanOn_r      <= 1'b0;
      scan_run_bit_r      <= 1'b0;
      scanInvalid_r <= 1'b1;
      scanIntm_r    <= 1'b0;
      scanMode_r    <= crc_scan_pkg::MODE_CONC;
      trigSel_r     <= 4'h0;
    end else if (scanOff) begin
      scanOn_r      <= 1'b0;
      scan_run_bit_r      <= 1'b0;
      scanInvalid_r <= 1'b1;
      scanIntm_r    <= 1'b0;
      scanMode_r    <= crc_scan_pkg::MODE_CONC;
      trigSel_r     <= 4'h0;
    end else begin
      if (scanDo & lastAddr) begin
        scan_run_bit_r      <= 1'b0;
        scanInvalid_r <= 1'b1;
      end
      if (wrCtrl) begin
        scanOn_r   <= hwdata[`SCTL_ON];
        scan_run_bit_r   <= hwdata[`SCTL_GO];
        scanIntm_r <= hwdata[`SCTL_INTERRUPT_PRIORITY_SELECT];
        scanMode_r <= hwdata[1:0];
        if (hwdata[`SCTL_GO]) begin
          scanInvalid_r <= 1'b0;
        end
      end
      if (wrPend_r & (wrIdx_r == `IDX_SCAN_TRIG)) begin
        trigSel_r <= hwdata[3:0];
      end
    end
  end

  // A trigger is remembered until served; one arriving in the serving
  // cycle is kept. A deferred request stays pending over the halt.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      trigPend_r <= 1'b0;
    end else if (scanOff) begin
      trigPend_r <= 1'b0;
    end else if (scanTrigger) begin
      trigPend_r <= 1'b1;
    end else if (scanDo) begin
      trigPend_r <= 1'b0;
    end
  end

  // ============================================================
  // CRC registers
  // Arithmetic lives elsewhere; here a data write marks the data path
  // full and a running enabled engine moves it to the shifter.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      crcData_r   <= `RST_HALF;
      crc_accumulator_r    <= `RST_HALF;
      crc_shifter_r  <= `RST_HALF;
      crcTaps_r   <= `RST_TAPS;
      crcEn_r     <= 1'b0;
      crcGo_r     <= 1'b0;
      crcAccm_r   <= 1'b0;
      crcShiftm_r <= 1'b0;
      crcFull_r   <= 1'b0;
      crcLen_r    <= `RST_BYTE;
    end else if (crcOff) begin
      crcData_r   <= `RST_HALF;
      crc_accumulator_r    <= `RST_HALF;
      crc_shifter_r  <= `RST_HALF;
      crcTaps_r   <= `RST_TAPS;
      crcEn_r     <= 1'b0;
      crcGo_r     <= 1'b0;
      crcAccm_r   <= 1'b0;
      crcShiftm_r <= 1'b0;
      crcFull_r   <= 1'b0;
      crcLen_r    <= `RST_BYTE;
    end else begin
      if (crcFull_r & crcEn_r & crcGo_r) begin
        crc_shifter_r <= crcData_r;
        crcFull_r  <= 1'b0;
      end
      if (wrPend_r) begin
        unique case (wrIdx_r)
          `IDX_CRC_DATA: begin
            crcData_r <= hwdata[15:0];
            crcFull_r <= 1'b1;
          end
          `IDX_CRC_ACC:  crc_accumulator_r  <= hwdata[15:0];
          `IDX_CRC_TAPS: crcTaps_r <= {hwdata[15:1], 1'b1};
          `IDX_CRC_CTRL: begin
            crcEn_r     <= hwdata[`CCTL_EN];
            crcGo_r     <= hwdata[`CCTL_GO];
            crcAccm_r   <= hwdata[`CCTL_ZERO_AUGMENT];
            crcShiftm_r <= hwdata[`CCTL_SHIFT_DIRECTION];
          end
          `IDX_CRC_LEN:  crcLen_r  <= hwdata[7:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ============================================================
  // Flash and core outputs
  // Burst holds the core off for the whole scan but releases it during
  // a halt so an external halt is never made to wait; the other
  // modes stall only for the cycle of each read, and peek never.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flashRead <= 1'b0;
      flashAddr <= `RST_ADDR;
      cpuStall  <= 1'b0;
    end else begin
      flashRead <= scanDo;
      if (scanDo) begin
        flashAddr <= scanLow_r;
      end
      if (burstMode) begin
        cpuStall <= scanPending & ~frozen & ~(scanDo & lastAddr);
      end else begin
        cpuStall <= scanDo &
                    (scanMode_r != crc_scan_pkg::MODE_PEEK);
      end
    end
  end

  // hsize is not checked; every transfer is taken as a word and needs no decode.
  logic [2:0] unusedSize;
  assign unusedSize = hsize;

endmodule

`default_nettype wire

// ---- tb/crc_scan_ctrl_properties.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========
// Port checker for the scanner debug and disable controller.
module crc_scan_ctrl_properties (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        scannerFuseEnable,
  input wire logic        pcBreak,
  input wire logic        dataBreak,
  input wire logic        stepDone,
  input wire logic        swBreak,
  input wire logic        extHalt,
  input wire logic        debugExit,
  input wire logic        flashRead,
  input wire logic [23:0] flashAddr,
  input wire logic        cpuStall,
  input wire logic        debugEnter,
  input wire logic        holderExec
);
  logic inHalt_r;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // Halted span as the core sees it, from entry pulse to exit pulse.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      inHalt_r <= 1'b0;
    end else if (debugEnter) begin
      inHalt_r <= 1'b1;
    end else if (debugExit) begin
      inHalt_r <= 1'b0;
    end
  end

  // A halt pulse counts only while the core runs; later ones are ignored.
  sequence haltOn(req);
    req && !inHalt_r && !debugEnter;
  endsequence

  sequence twoReads;
    flashRead ##1 flashRead;
  endsequence

  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  pc_entry_a: assert property (haltOn(pcBreak) |=> debugEnter)
    else $error("no entry after pc break");
  data_defer_a: assert property (
    haltOn(dataBreak) |=> debugEnter && !flashRead)
    else $error("scan not deferred on data break");
  step_entry_a: assert property (haltOn(stepDone) |=> debugEnter)
    else $error("no entry after step");
  sw_entry_a: assert property (haltOn(swBreak) |=> debugEnter)
    else $error("no entry after software break");
  ext_yield_a: assert property (
    haltOn(extHalt) |=> debugEnter ##1 (!cpuStall && !flashRead))
    else $error("burst did not yield to halt");
  halt_freeze_a: assert property (inHalt_r |-> !flashRead)
    else $error("scanner read while halted");
  holder_exit_a: assert property (holderExec |-> $past(debugExit))
    else $error("holder run without exit");
  fuse_gone_a: assert property (
    (!scannerFuseEnable)[*2] |-> !flashRead)
    else $error("read with scanner fuse off");
  addr_step_a: assert property (
    twoReads |-> flashAddr == $past(flashAddr) + 24'h00_0001)
    else $error("scan address did not step by one");
endmodule

bind crc_scan_ctrl crc_scan_ctrl_properties crc_scan_ctrl_properties_i (
  .mclk, .rstn, .hreadyout, .hresp, .scannerFuseEnable, .pcBreak,
  .dataBreak, .stepDone, .swBreak, .extHalt, .debugExit, .flashRead,
  .flashAddr, .cpuStall, .debugEnter, .holderExec
);

`default_nettype wire

// ---- tb/debug_core_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========
// Core and debug halt logic: one-cycle halt pulses, exit on request.
module debug_core_model (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic [2:0] haltReq,
  input  wire logic       exitReq,
  input  wire logic       debugEnter,
  output logic      [4:0] haltPulse,
  output logic            debugExit,
  output logic            deadCycle
);
  logic inHalt;

  // A new halt is never raised while halted, so none is refused.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      haltPulse <= 5'h00;
      debugExit <= 1'b0;
      inHalt    <= 1'b0;
      deadCycle <= 1'b0;
    end else begin
      haltPulse <= 5'h00;
      debugExit <= 1'b0;
      deadCycle <= ~deadCycle;
      if (haltReq != 3'h0 && !inHalt && haltPulse == 5'h00)
        haltPulse <= 5'h01 << (haltReq - 3'h1);
      if (debugEnter)
        inHalt <= 1'b1;
      if (exitReq && inHalt) begin
        debugExit <= 1'b1;
        inHalt    <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// ---- tb/tb_crc_scan_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "crc_scan_regs.svh"

module tb_crc_scan_ctrl;
  logic        mclk, rstn, hsel, hwrite, hreadyout, hresp, scanTrigger;
  logic        deadCycle, exitReq, onGoInstr, flashRead, cpuStall;
  logic        debugEnter, holderExec, debugExit, scannerFuseEnable, trigOn;
  logic [31:0] haddr, hwdata, hrdata, rdata, rdata2;
  logic [1:0]  htrans;
  logic [2:0]  hsize, haltReq;
  logic [4:0]  haltPulse;
  logic [23:0] flashAddr;
  int          n_mismatch, checks_done, cycles, nReads, stallSeen;

  crc_scan_ctrl crc_scan_ctrl_i (
    .mclk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .scannerFuseEnable,
    .scanTrigger, .deadCycle, .pcBreak(haltPulse[0]),
    .dataBreak(haltPulse[1]), .stepDone(haltPulse[2]),
    .swBreak(haltPulse[3]), .extHalt(haltPulse[4]), .onGoInstr,
    .debugExit, .flashRead, .flashAddr, .cpuStall, .debugEnter,
    .holderExec
  );

  debug_core_model debug_core_model_i (
    .mclk, .rstn, .haltReq, .exitReq, .debugEnter, .haltPulse,
    .debugExit, .deadCycle
  );

  // ==========
  // Clock, counters and hang guard.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Counts reads and stalls; the trigger toggles only when asked.
  always @(posedge mclk) begin
    cycles++;
    scanTrigger <= trigOn & ~scanTrigger;
    if (flashRead === 1'b1)
      nReads++;
    if (cpuStall === 1'b1)
      stallSeen++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ==========
  // Shared tasks.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  // One single transfer; ends off the edge so counters never race it.
  task automatic bus(input logic wr, input logic [11:0] idx,
                     input logic [31:0] wd);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= {18'h0_0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdata = hrdata;
    #1;
  endtask

  task automatic scan(input logic [31:0] lo, hi, ctl);
    bus(1'b1, `IDX_SCAN_LOW, lo);
    bus(1'b1, `IDX_SCAN_HIGH, hi);
    bus(1'b1, `IDX_SCAN_CTRL, ctl);
  endtask

  // Polls go with a bounded count.
  task automatic wait_idle();
    for (int i = 0; i < 200; i++) begin
      bus(1'b0, `IDX_SCAN_CTRL, 32'h0);
      if (rdata[`SCTL_GO] === 1'b0)
        break;
    end
    check(rdata[`SCTL_GO], 0, "go did not clear");
  endtask

  task automatic halt(input logic [2:0] code, input logic expRead);
    @(posedge mclk);
    haltReq <= code;
    @(posedge mclk);
    haltReq <= 3'h0;
    @(posedge mclk);
    #1;
    check(debugEnter, 1, "no debug entry");
    check(flashRead, expRead, "scan at entry");
    @(posedge mclk);
    #1;
  endtask

  task automatic leave(input logic expHolder);
    @(posedge mclk);
    exitReq <= 1'b1;
    @(posedge mclk);
    exitReq <= 1'b0;
    @(posedge mclk);
    #1;
    check(holderExec, expHolder, "holder run at exit");
  endtask

  // ==========
  // Scenarios.
  task automatic test_reset();
    bus(1'b0, `IDX_SCAN_LOW, 32'h0);
    check(rdata, 0, "scan low reset");
    bus(1'b0, `IDX_CRC_TAPS, 32'h0);
    check(rdata, 32'h0000_0001, "tap bit zero");
    bus(1'b1, 12'h100, 32'hffff_ffff);
    bus(1'b0, 12'h100, 32'h0);
    check(rdata, 0, "unmapped read");
    bus(1'b0, `IDX_PERIPH_DIS, 32'h0);
    check(rdata, 32'h0000_0004, "fuse bit visible");
  endtask

  // Every mode code runs a two-word scan to its end.
  task automatic test_modes();
    trigOn = 1'b1;
    for (int k = 0; k < 4; k++) begin
      nReads = 0;
      stallSeen = 0;
      scan(32'h0000_0200, 32'h0000_0201, 32'h0000_00c0 + 32'(k));
      wait_idle();
      check(nReads, 2, "mode read count");
      if (k == 1)
        check(stallSeen != 0, 1, "burst stall");
    end
    trigOn = 1'b0;
  endtask

  // Each halt kind but the external halt lands on a running concurrent scan.
  task automatic test_halts();
    int r;
    for (int k = 1; k <= 4; k++) begin
      scan(32'h0, 32'h0000_0fff, 32'h0000_00c0);
      halt(3'(k), k != 2);
      r = nReads;
      bus(1'b0, `IDX_SCAN_LOW, 32'h0);
      rdata2 = rdata;
      bus(1'b0, `IDX_SCAN_LOW, 32'h0);
      check(rdata, rdata2, "address moved in halt");
      check(nReads, r, "read in halt");
      leave(1'b0);
      repeat (4) @(posedge mclk);
      #1;
      check(nReads > r, 1, "scan not resumed");
      bus(1'b1, `IDX_SCAN_CTRL, 32'h0);
    end
  endtask

  // Breaks on the go instruction, then a halt inside a running burst.
  task automatic test_burst();
    int r;
    scan(32'h0, 32'h0000_003f, 32'h0000_0081);
    onGoInstr <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      halt(k == 0 ? 3'h1 : 3'h4, 1'b0);
      leave(k == 1);
    end
    onGoInstr <= 1'b0;
    nReads = 0;
    bus(1'b1, `IDX_SCAN_CTRL, 32'h0000_00c1);
    halt(3'h5, 1'b1);
    check(cpuStall, 0, "stall held in halt");
    r = nReads;
    repeat (3) @(posedge mclk);
    #1;
    check(nReads, r, "burst read in halt");
    leave(1'b0);
    wait_idle();
    check(nReads, 64, "burst incomplete");
  endtask

  task automatic test_disable();
    int r;
    bus(1'b1, `IDX_PERIPH_DIS, 32'h0000_0002);
    bus(1'b1, `IDX_SCAN_LOW, 32'h0000_0055);
    bus(1'b0, `IDX_SCAN_LOW, 32'h0);
    check(rdata, 0, "write to disabled scanner");
    r = nReads;
    bus(1'b1, `IDX_SCAN_CTRL, 32'h0000_00c0);
    repeat (5) @(posedge mclk);
    #1;
    check(nReads, r, "disabled scanner read");
    bus(1'b1, `IDX_CRC_ACC, 32'h0000_1234);
    bus(1'b0, `IDX_CRC_ACC, 32'h0);
    check(rdata, 32'h0000_1234, "crc lost write");
    bus(1'b1, `IDX_PERIPH_DIS, 32'h0000_0001);
    bus(1'b0, `IDX_CRC_ACC, 32'h0);
    check(rdata, 0, "crc not held in reset");
    bus(1'b1, `IDX_SCAN_LOW, 32'h0000_0055);
    bus(1'b0, `IDX_SCAN_LOW, 32'h0);
    check(rdata, 32'h0000_0055, "scanner not back");
    scannerFuseEnable <= 1'b0;
    bus(1'b1, `IDX_PERIPH_DIS, 32'h0);
    bus(1'b1, `IDX_SCAN_LOW, 32'h0000_0066);
    bus(1'b0, `IDX_SCAN_LOW, 32'h0);
    check(rdata, 0, "scanner with fuse off");
    bus(1'b0, `IDX_PERIPH_DIS, 32'h0);
    check(rdata[`PDIS_FUSE], 0, "fuse bit");
    scannerFuseEnable <= 1'b1;
  endtask

  // ==========
  // Main sequence.
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    haltReq = 3'h0;
    exitReq = 1'b0;
    onGoInstr = 1'b0;
    scannerFuseEnable = 1'b1;
    trigOn = 1'b0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    test_reset();
    $display("reset test done");
    test_modes();
    $display("mode test done");
    test_halts();
    $display("halt test done");
    test_burst();
    $display("burst test done");
    test_disable();
    $display("disable test done");
    end_sim();
  end
endmodule

`default_nettype wire
